// file: shared/sr_pkg.sv
package sr_pkg;

  // *****************************************************************
  // widths, masks and reset values
  // *****************************************************************
  localparam int          SR_W           = 16;
  localparam logic [15:0] SR_WR_MASK     = 16'h7fff;
  localparam logic [15:0] SR_MAX_VAL     = 16'h7fff;
  localparam logic [15:0] SR_RST_VAL     = 16'h0000;
  localparam logic [15:0] SR_RISE_PRESET = 16'h7fff;
  localparam logic [15:0] SR_FALL_PRESET = 16'h0000;
  localparam logic [15:0] SR_EN_PRESET   = 16'h0000;

  // *****************************************************************
  // condition bit positions
  // *****************************************************************
  localparam int SR_OP_B0  = 0;
  localparam int SR_OP_LO  = 8;
  localparam int SR_OP_NHI = 5;
  localparam int SR_QU_B2  = 2;
  localparam int SR_QU_B5  = 5;
  localparam int SR_QU_B6  = 6;

  // *****************************************************************
  // status byte positions
  // *****************************************************************
  localparam int SR_STB_QUAL = 3;
  localparam int SR_STB_OPER = 7;

  // *****************************************************************
  // register select and number notation
  // *****************************************************************
  typedef enum logic [2:0] {
    SR_COND   = 3'b000,
    SR_EVENT  = 3'b001,
    SR_ENABLE = 3'b010,
    SR_FALL   = 3'b011,
    SR_RISE   = 3'b100
  } sr_reg_e;

  typedef enum logic [1:0] {
    SR_DEC = 2'b00,
    SR_HEX = 2'b01,
    SR_OCT = 2'b10,
    SR_BIN = 2'b11
  } sr_radix_e;

endpackage

// file: shared/sr_grp_if.sv
`timescale 1ns/1ps
interface sr_grp_if;
  import sr_pkg::*;
  logic        wr;
  logic        rd;
  logic        preset;
  sr_reg_e     sel;
  logic [15:0] wdata;
  logic [15:0] cond;
  logic [15:0] rdata;
  logic        summary;

  modport ctrl (output wr, rd, preset, sel, wdata, cond,
                input  rdata, summary);
  modport grp  (input  wr, rd, preset, sel, wdata, cond,
                output rdata, summary);
endinterface

// file: hw/sr_num_conv.sv
`timescale 1ns/1ps
module sr_num_conv
  import sr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic        digit_valid,
  input  wire logic [3:0]  digit,
  input  wire sr_radix_e   radix,
  output logic      [15:0] value,
  output logic             over,
  output logic             bad
);

  logic [15:0] acc_q;
  logic        over_q;
  logic        bad_q;
  logic [4:0]  base;
  logic [20:0] prod;

  always_comb begin
    unique case (radix)
      SR_DEC: base = 5'h0a;
      SR_HEX: base = 5'h10;
      SR_OCT: base = 5'h08;
      SR_BIN: base = 5'h02;
    endcase
    prod = 21'(acc_q) * 21'(base) + 21'(digit);
  end

  // every notation folds into one binary value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_q  <= 16'h0000;
      over_q <= 1'b0;
      bad_q  <= 1'b0;
    end else if (start) begin
      acc_q  <= 16'h0000;
      over_q <= 1'b0;
      bad_q  <= 1'b0;
    end else if (digit_valid) begin
      if ({1'b0, digit} >= base) begin
        bad_q <= 1'b1;
      end else if (prod > 21'(SR_MAX_VAL)) begin
        over_q <= 1'b1;
      end else begin
        acc_q <= prod[15:0];
      end
    end
  end

  assign value = acc_q;
  assign over  = over_q;
  assign bad   = bad_q;

endmodule // sr_num_conv

// file: hw/sr_group.sv
`timescale 1ns/1ps
module sr_group
  import sr_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  sr_grp_if.grp     bus
);

  logic [15:0] cond_q;
  logic [15:0] event_q;
  logic [15:0] enable_q;
  logic [15:0] fall_q;
  logic [15:0] rise_q;
  logic [15:0] set_bits;
  logic [15:0] wval;

  assign wval = bus.wdata & SR_WR_MASK;
  // filtered edges of the live condition
  assign set_bits = (bus.cond & ~cond_q & rise_q)
                  | (~bus.cond & cond_q & fall_q);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) cond_q <= SR_RST_VAL;
    else        cond_q <= bus.cond;
  end

  // new edges win over the read clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      event_q <= SR_RST_VAL;
    end else if (bus.rd && bus.sel == SR_EVENT) begin
      event_q <= set_bits & SR_WR_MASK;
    end else begin
      event_q <= (event_q | set_bits) & SR_WR_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= SR_RST_VAL;
      fall_q   <= SR_RST_VAL;
      rise_q   <= SR_RST_VAL;
    end else if (bus.preset) begin
      enable_q <= SR_EN_PRESET;
      fall_q   <= SR_FALL_PRESET;
      rise_q   <= SR_RISE_PRESET & SR_WR_MASK;
    end else if (bus.wr) begin
      if (bus.sel == SR_ENABLE) enable_q <= wval;
      if (bus.sel == SR_FALL)   fall_q   <= wval;
      if (bus.sel == SR_RISE)   rise_q   <= wval;
    end
  end

  always_comb begin
    unique case (bus.sel)
      SR_COND:   bus.rdata = cond_q & SR_WR_MASK;
      SR_EVENT:  bus.rdata = event_q;
      SR_ENABLE: bus.rdata = enable_q;
      SR_FALL:   bus.rdata = fall_q;
      SR_RISE:   bus.rdata = rise_q;
      default:   bus.rdata = 16'h0000;
    endcase
  end

  assign bus.summary = |(event_q & enable_q);

endmodule // sr_group

// file: hw/sr_status_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - values 0..32767 accepted, bits 0-14 writable, written registers reset zero
// - bit n weighs two to the n; bit 15 carries no weight
// - decimal, hex, octal and binary digits all give one binary value
// - operation condition is 16 bits, only bits 0 and 8-12 driven
// - each group has condition, event, enable, rise and fall registers
// - operation event read returns contents then clears them
// - event bit sets on a rise through rise filter or fall through fall filter
// - operation condition read shows live bits and changes nothing
// - operation enable write loads value; read returns it unchanged
// - fall filter write loads addressed group's fall register, readable
// - rise filter write loads addressed group's rise register, readable
// - quality condition drives only bits 2, 5 and 6
// - status byte bit 3 is any enabled quality event
// - quality event read returns contents then clears them
// - quality condition read shows live bits and changes nothing
// - enable read back modifies no status register
// - preset clears enables, sets rise filters, clears fall filters
// - status byte bit 7 is any enabled operation event
module sr_status_top
  import sr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [5:0]  op_ind,
  input  wire logic [2:0]  qual_ind,
  input  wire logic        num_start,
  input  wire logic        num_digit_valid,
  input  wire logic [3:0]  num_digit,
  input  wire sr_radix_e   num_radix,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_preset,
  input  wire logic        cmd_group,
  input  wire sr_reg_e     cmd_reg,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic             rsp_error,
  output logic      [15:0] rsp_data,
  output logic      [7:0]  status_byte
);

  // *****************************************************************
  // sequencing state
  // *****************************************************************
  typedef enum logic [0:0] {
    SR_IDLE = 1'b0,
    SR_EXEC = 1'b1
  } sr_state_e;

  sr_state_e   state_q;
  sr_state_e   state_d;
  logic        take;
  logic        wr_q;
  logic        preset_q;
  logic        group_q;
  sr_reg_e     reg_q;
  logic        err_q;
  logic [15:0] wdata_q;
  logic        cmd_ready_q;
  logic        rsp_valid_q;
  logic        rsp_error_q;
  logic [15:0] rsp_data_q;
  logic [7:0]  stb_q;
  logic [15:0] op_cond;
  logic [15:0] qu_cond;
  logic [15:0] num_value;
  logic        num_over;
  logic        num_bad;
  logic        bad_write;
  logic        sel_ok;
  logic        do_wr;
  logic        do_rd;
  logic        do_preset;
  logic [15:0] rdata_sel;

  sr_grp_if op_bus ();
  sr_grp_if qu_bus ();

  // *****************************************************************
  // number entry
  // *****************************************************************
  sr_num_conv u_conv (
    .clock       (clock),
    .rst_b       (rst_b),
    .start       (num_start),
    .digit_valid (num_digit_valid),
    .digit       (num_digit),
    .radix       (num_radix),
    .value       (num_value),
    .over        (num_over),
    .bad         (num_bad)
  );

  // *****************************************************************
  // live condition bits
  // *****************************************************************
  always_comb begin
    op_cond = 16'h0000;
    op_cond[SR_OP_B0] = op_ind[0];
    op_cond[SR_OP_LO +: SR_OP_NHI] = op_ind[5:1];
  end

  always_comb begin
    qu_cond = 16'h0000;
    qu_cond[SR_QU_B2] = qual_ind[0];
    qu_cond[SR_QU_B5] = qual_ind[1];
    qu_cond[SR_QU_B6] = qual_ind[2];
  end

  // *****************************************************************
  // command acceptance
  // *****************************************************************
  assign take   = cmd_valid && cmd_ready_q;
  assign sel_ok = cmd_reg inside {SR_COND, SR_EVENT, SR_ENABLE,
                                  SR_FALL, SR_RISE};

  // condition and event registers are read only
  always_comb begin
    bad_write = 1'b0;
    if (!cmd_preset && cmd_write) begin
      bad_write = num_over || num_bad
                || cmd_reg == SR_COND || cmd_reg == SR_EVENT;
    end
    if (!cmd_preset && !sel_ok) begin
      bad_write = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SR_IDLE: if (take) state_d = SR_EXEC;
      SR_EXEC: state_d = SR_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state_q <= SR_IDLE;
    else        state_q <= state_d;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) cmd_ready_q <= 1'b1;
    else        cmd_ready_q <= (state_d == SR_IDLE);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_q     <= 1'b0;
      preset_q <= 1'b0;
      group_q  <= 1'b0;
      reg_q    <= SR_COND;
      err_q    <= 1'b0;
      wdata_q  <= 16'h0000;
    end else if (take) begin
      wr_q     <= cmd_write;
      preset_q <= cmd_preset;
      group_q  <= cmd_group;
      reg_q    <= sel_ok ? cmd_reg : SR_COND;
      err_q    <= bad_write;
      wdata_q  <= num_value & SR_WR_MASK;
    end
  end

  // *****************************************************************
  // group strobes
  // *****************************************************************
  assign do_preset = (state_q == SR_EXEC) && preset_q && !err_q;
  assign do_wr = (state_q == SR_EXEC) && !preset_q && wr_q && !err_q;
  assign do_rd = (state_q == SR_EXEC) && !preset_q && !wr_q && !err_q;

  assign op_bus.cond   = op_cond;
  assign op_bus.sel    = reg_q;
  assign op_bus.wdata  = wdata_q;
  assign op_bus.preset = do_preset;
  assign op_bus.wr     = do_wr && !group_q;
  assign op_bus.rd     = do_rd && !group_q;

  assign qu_bus.cond   = qu_cond;
  assign qu_bus.sel    = reg_q;
  assign qu_bus.wdata  = wdata_q;
  assign qu_bus.preset = do_preset;
  assign qu_bus.wr     = do_wr && group_q;
  assign qu_bus.rd     = do_rd && group_q;

  // *****************************************************************
  // the two status groups
  // *****************************************************************
  sr_group u_op (
    .clock (clock),
    .rst_b (rst_b),
    .bus   (op_bus.grp)
  );

  sr_group u_qu (
    .clock (clock),
    .rst_b (rst_b),
    .bus   (qu_bus.grp)
  );

  // *****************************************************************
  // response
  // *****************************************************************
  assign rdata_sel = group_q ? qu_bus.rdata : op_bus.rdata;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
    end else begin
      rsp_valid_q <= (state_q == SR_EXEC);
      rsp_error_q <= (state_q == SR_EXEC) && err_q;
    end
  end

  // value read before the clear takes effect
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rsp_data_q <= 16'h0000;
    end else if (state_q == SR_EXEC) begin
      rsp_data_q <= do_rd ? rdata_sel : 16'h0000;
    end
  end

  // *****************************************************************
  // status byte summaries
  // *****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stb_q <= 8'h00;
    end else begin
      stb_q <= 8'h00;
      stb_q[SR_STB_QUAL] <= qu_bus.summary;
      stb_q[SR_STB_OPER] <= op_bus.summary;
    end
  end

  assign cmd_ready   = cmd_ready_q;
  assign rsp_valid   = rsp_valid_q;
  assign rsp_error   = rsp_error_q;
  assign rsp_data    = rsp_data_q;
  assign status_byte = stb_q;

endmodule // sr_status_top

// file: verif/sr_status_chk.sv
`timescale 1ns/1ps
module sr_status_chk
  import sr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic        cmd_preset,
  input wire sr_reg_e     cmd_reg,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_error,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0]  status_byte
);
  logic take;
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_resp_two_edges: assert property (take |-> ##2 rsp_valid)
    else $error("response not two edges after take");
  a_ready_gap: assert property (take |=> !cmd_ready ##1 cmd_ready)
    else $error("ready not low for one cycle after take");
  a_resp_single: assert property (rsp_valid |=> !rsp_valid)
    else $error("response wider than one cycle");
  a_resp_cause: assert property (rsp_valid |-> $past(take, 2))
    else $error("response without a command");
  a_top_bit_zero: assert property (rsp_valid |-> !rsp_data[15])
    else $error("bit 15 read as one");
  a_err_no_data: assert property (rsp_valid && rsp_error |->
    rsp_data == 16'h0000) else $error("refused answer carries data");
  a_ro_refused: assert property (take && cmd_write && !cmd_preset &&
    (cmd_reg == SR_COND || cmd_reg == SR_EVENT) |-> ##2 rsp_error)
    else $error("write to read-only place accepted");
  a_bad_code: assert property (take && !cmd_preset &&
    cmd_reg > SR_RISE |-> ##2 rsp_error)
    else $error("unknown register code accepted");
  a_preset_clr: assert property (take && cmd_preset |->
    ##2 (rsp_valid && !rsp_error) ##1 status_byte == 8'h00)
    else $error("preset left a summary bit set");

  c_preset: cover property (take && cmd_preset);
  c_refused: cover property (rsp_valid && rsp_error);
  c_both_sum: cover property (status_byte[7] && status_byte[3]);
endmodule // sr_status_chk

bind sr_status_top sr_status_chk u_chk (
  .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_preset(cmd_preset), .cmd_reg(cmd_reg),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
  .rsp_data(rsp_data), .status_byte(status_byte)
);

// file: verif/sr_host.sv
`timescale 1ns/1ps
module sr_host
  import sr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic [15:0] rsp_data,
  output logic             num_start,
  output logic             num_digit_valid,
  output logic      [3:0]  num_digit,
  output sr_radix_e        num_radix,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_preset,
  output logic             cmd_group,
  output sr_reg_e          cmd_reg
);
  initial begin
    {num_start, num_digit_valid, num_digit} = 6'h00;
    num_radix = SR_DEC;
    {cmd_valid, cmd_write, cmd_preset, cmd_group} = 4'h0;
    cmd_reg = SR_COND;
  end

  // digits most significant first, in any of four notations
  task automatic number(input sr_radix_e r, input int v);
    int b;
    int p;
    b = (r == SR_DEC) ? 10 : (r == SR_HEX) ? 16 : (r == SR_OCT) ? 8 : 2;
    p = 1;
    while (p * b <= v) p = p * b;
    @(posedge clock) #2;
    num_radix = r;
    num_start = 1'b1;
    while (p > 0) begin
      @(posedge clock) #2;
      num_start = 1'b0;
      num_digit_valid = 1'b1;
      num_digit = 4'((v / p) % b);
      p = p / b;
    end
    @(posedge clock) #2;
    num_digit_valid = 1'b0;
    num_digit = ~num_digit;
  endtask

  // one digit that the chosen notation cannot hold
  task automatic bad_digit(input sr_radix_e r, input logic [3:0] dg);
    @(posedge clock) #2;
    num_radix = r;
    num_start = 1'b1;
    @(posedge clock) #2;
    num_start = 1'b0;
    num_digit_valid = 1'b1;
    num_digit = dg;
    @(posedge clock) #2;
    num_digit_valid = 1'b0;
  endtask

  task automatic cmd(input logic w, p, g, input sr_reg_e r,
                     output logic ok, e, output logic [15:0] d);
    @(posedge clock) #2;
    {cmd_valid, cmd_write, cmd_preset, cmd_group} = {1'b1, w, p, g};
    cmd_reg = r;
    while (!cmd_ready) @(posedge clock) #2;
    @(posedge clock) #2;
    // released fields show garbage, not the last request
    cmd_valid = 1'b0;
    {cmd_write, cmd_preset, cmd_group} = ~{w, p, g};
    cmd_reg = sr_reg_e'(~r);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clock) #2;
      ok = rsp_valid;
      e = rsp_error;
      d = rsp_data;
    end
  endtask
endmodule // sr_host

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sr_pkg::*;
  typedef struct {
    logic g; sr_reg_e r; sr_radix_e x; int v; logic e; logic [15:0] q;
  } sr_row_s;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] op_ind = 6'h00;
  logic [2:0] qual_ind = 3'h0;
  logic num_start, num_digit_valid, cmd_valid, cmd_write, cmd_preset;
  logic cmd_group, cmd_ready, rsp_valid, rsp_error, h_ok, h_er;
  logic [3:0] num_digit;
  logic [15:0] rsp_data, h_d;
  logic [7:0] status_byte;
  sr_radix_e num_radix;
  sr_reg_e cmd_reg;
  int failures = 0;
  int checks_done = 0;
  sr_row_s rows [9] = '{
    '{1'b0, SR_ENABLE, SR_DEC, 64, 1'b0, 16'h0040},
    '{1'b0, SR_FALL, SR_HEX, 32767, 1'b0, 16'h7fff},
    '{1'b0, SR_RISE, SR_OCT, 511, 1'b0, 16'h01ff},
    '{1'b1, SR_ENABLE, SR_BIN, 5, 1'b0, 16'h0005},
    '{1'b1, SR_FALL, SR_DEC, 16384, 1'b0, 16'h4000},
    '{1'b1, SR_RISE, SR_HEX, 4660, 1'b0, 16'h1234},
    '{1'b0, SR_ENABLE, SR_DEC, 32768, 1'b1, 16'h0040},
    '{1'b1, SR_EVENT, SR_DEC, 7, 1'b1, 16'h0000},
    '{1'b0, SR_COND, SR_DEC, 1, 1'b1, 16'h0000}};

  always #12.5 clock = ~clock;

  sr_status_top dut (.clock(clock), .rst_b(rst_b), .op_ind(op_ind),
    .qual_ind(qual_ind), .num_start(num_start),
    .num_digit_valid(num_digit_valid), .num_digit(num_digit),
    .num_radix(num_radix), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_preset(cmd_preset), .cmd_group(cmd_group), .cmd_reg(cmd_reg),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_data(rsp_data), .status_byte(status_byte));
  sr_host host (.clock(clock), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data),
    .num_start(num_start), .num_digit_valid(num_digit_valid),
    .num_digit(num_digit), .num_radix(num_radix), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_preset(cmd_preset),
    .cmd_group(cmd_group), .cmd_reg(cmd_reg));

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic g, input sr_reg_e r, input logic [15:0] q);
    host.cmd(1'b0, 1'b0, g, r, h_ok, h_er, h_d);
    chk({h_ok, h_er, h_d}, {2'b10, q});
  endtask

  task automatic wr(input logic g, input sr_reg_e r, input sr_radix_e x,
                    input int v, input logic e);
    host.number(x, v);
    host.cmd(1'b1, 1'b0, g, r, h_ok, h_er, h_d);
    chk({h_ok, h_er, h_d}, {1'b1, e, 16'h0000});
  endtask

  task automatic ind(input logic [5:0] o, input logic [2:0] q);
    @(posedge clock) #2;
    op_ind = o;
    qual_ind = q;
    repeat (4) @(posedge clock);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge clock);
    #2 rst_b = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].g, rows[i].r, rows[i].x, rows[i].v, rows[i].e);
      rd(rows[i].g, rows[i].r, rows[i].q);
    end
    host.cmd(1'b0, 1'b1, 1'b0, SR_COND, h_ok, h_er, h_d);
    chk({h_ok, h_er, h_d}, 18'h20000);
    for (int g = 0; g < 2; g++) begin
      rd(g[0], SR_ENABLE, 16'h0000);
      rd(g[0], SR_FALL, 16'h0000);
      rd(g[0], SR_RISE, 16'h7fff);
    end
    wr(1'b0, SR_ENABLE, SR_HEX, 32767, 1'b0);
    wr(1'b1, SR_ENABLE, SR_DEC, 4, 1'b0);
    ind(6'h3f, 3'h7);
    chk(18'(status_byte), 18'h00088);
    rd(1'b0, SR_COND, 16'h1f01);
    rd(1'b1, SR_COND, 16'h0064);
    wr(1'b1, SR_ENABLE, SR_OCT, 8, 1'b0);
    repeat (2) @(posedge clock);
    chk(18'(status_byte), 18'h00080);
    ind(6'h00, 3'h0);
    rd(1'b0, SR_EVENT, 16'h1f01);
    rd(1'b0, SR_EVENT, 16'h0000);
    rd(1'b1, SR_EVENT, 16'h0064);
    rd(1'b1, SR_EVENT, 16'h0000);
    repeat (2) @(posedge clock);
    chk(18'(status_byte), 18'h00000);
    wr(1'b0, SR_FALL, SR_BIN, 1, 1'b0);
    wr(1'b0, SR_RISE, SR_DEC, 0, 1'b0);
    ind(6'h01, 3'h0);
    rd(1'b0, SR_EVENT, 16'h0000);
    ind(6'h00, 3'h0);
    rd(1'b0, SR_EVENT, 16'h0001);
    rd(1'b0, SR_ENABLE, 16'h7fff);
    rd(1'b0, SR_ENABLE, 16'h7fff);
    host.cmd(1'b0, 1'b0, 1'b0, sr_reg_e'(3'h5), h_ok, h_er, h_d);
    chk({h_ok, h_er, h_d}, 18'h30000);
    host.bad_digit(SR_BIN, 4'h2);
    host.cmd(1'b1, 1'b0, 1'b0, SR_ENABLE, h_ok, h_er, h_d);
    chk({h_ok, h_er, h_d}, 18'h30000);
    rd(1'b0, SR_ENABLE, 16'h7fff);
    @(posedge clock) #2 rst_b = 1'b0;
    repeat (4) @(posedge clock);
    #2 rst_b = 1'b1;
    for (int g = 0; g < 2; g++) begin
      for (int r = 0; r < 5; r++) begin
        rd(g[0], sr_reg_e'(r[2:0]), 16'h0000);
      end
    end
    print_verdict;
  end
endmodule // testbench
